/* hkl_consts.svh */
// Purpose: constants of the key and LED process image block
// Assumes: 50 MHz system clock, classic Wishbone register access
// Notes: one rule to a line below, tag first
// Function
// R01 - each function key bit reads 1 while pressed, 0 while released
// R02 - input byte n holds function keys one to eight at bits 0 to 7
// R03 - input byte n+1 holds right lit button at bit 7, left at bit 6
// R04 - keyswitch in byte n+1 bits 5:4: 00 middle, 01 clockwise, 10 counter-clockwise
// R05 - largest variant adds key nine at bit 0, key ten at bit 1 of n+1
// R06 - bytes n+2 to n+5 carry 32 touch key bits, LSB first
// R07 - each lit button bit reads 1 while pressed, 0 otherwise
// R08 - output image uses key layout; 1 lights LED steadily, 0 turns it off (code: a 0 leaves the LED to its tag field)
// R09 - direct key exchange only while a cyclic fieldbus connection exists
// R10 - function keys and their LEDs only after the runtime project started
// R11 - keyswitch, lit buttons and their LEDs once attached to a connection box
// R12 - LED tag fields: 00 off, 01 fast flash, 10 slow flash, 11 on
// R13 - one function per key; screen-local assignment overrides the global one
// R14 - runtime switching among online, offline and load (transfer) modes
// R15 - unassigned input bits read 0; unassigned output bits are ignored
`ifndef HKL_CONSTS_SVH
`define HKL_CONSTS_SVH

// register byte addresses
`define HKL_ADR_IN_LO      8'h00
`define HKL_ADR_IN_HI      8'h04
`define HKL_ADR_OUT_IMG    8'h08
`define HKL_ADR_LED_TAG    8'h0C
`define HKL_ADR_MODE       8'h10
`define HKL_ADR_LOCAL      8'h14
`define HKL_ADR_IRQ_STAT   8'h18
`define HKL_ADR_IRQ_MASK   8'h1C
`define HKL_ADR_LINK       8'h20

// bit positions inside the 16-bit key / LED image (bytes n and n+1)
`define HKL_POS_KEY_NINE   8
`define HKL_POS_KEY_TEN    9
`define HKL_POS_LOCK_LO    12
`define HKL_POS_LOCK_HI    13
`define HKL_POS_LEFT       14
`define HKL_POS_RIGHT      15

// interrupt status bits
`define HKL_IRQ_IN_CHANGE  0
`define HKL_IRQ_OUT_WRITE  1
`define HKL_IRQ_MODE       2
`define HKL_IRQ_LINK       3

// reset values
`define HKL_RST_OUT_IMG    16'h0000
`define HKL_RST_LED_TAG    24'h000000
`define HKL_RST_LOCAL      10'h000
`define HKL_RST_IRQ_MASK   4'h0

// flash timing
`define HKL_CLK_HZ         50000000
`define HKL_FAST_HALF_MS   125
`define HKL_SLOW_HALF_MS   500
`define HKL_FAST_HALF_CYC  ((`HKL_CLK_HZ / 1000) * `HKL_FAST_HALF_MS)
`define HKL_SLOW_HALF_CYC  ((`HKL_CLK_HZ / 1000) * `HKL_SLOW_HALF_MS)

`endif

/* hkl_pkg.sv */
// Purpose: types of the key and LED process image block
// Assumes: nothing beyond the constants header
// Notes: mode codes are shared by register and output
package hkl_pkg;

  typedef enum logic [1:0]
  {
    HKL_MODE_OFFLINE = 2'b00,
    HKL_MODE_ONLINE  = 2'b01,
    HKL_MODE_LOAD    = 2'b10
  } hkl_mode_type;

  typedef enum logic [1:0]
  {
    HKL_VAR_SMALL = 2'b00,
    HKL_VAR_MID   = 2'b01,
    HKL_VAR_LARGE = 2'b10
  } hkl_variant_type;

  typedef enum logic [1:0]
  {
    HKL_LED_OFF  = 2'b00,
    HKL_LED_FAST = 2'b01,
    HKL_LED_SLOW = 2'b10,
    HKL_LED_ON   = 2'b11
  } hkl_led_code_type;

endpackage

/* hkl_lamp_if.sv */
// Purpose: carrier between image logic and lamp driver
// Assumes: twelve lamps, two code bits each
// Notes: lamps 0..9 function keys, 10 left, 11 right lit button
`timescale 1ns/10ps
`default_nettype none
interface hkl_lamp_if;
  logic [23:0] code;
  logic [11:0] lit;
  modport ctrl   (output code, input lit);
  modport driver (input code, output lit);
endinterface
`default_nettype wire

/* hkl_lamp_driver.sv */
// Purpose: turn two-bit LED codes into lamp levels
// Assumes: codes come from the same clock domain
// Notes: both flash phases free-run so lamps of one rate blink together
`timescale 1ns/10ps
`default_nettype none
module hkl_lamp_driver
  import hkl_pkg::*;
#(
  parameter int unsigned FAST_HALF = 6250000,
  parameter int unsigned SLOW_HALF = 25000000
)
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // codes in, levels out
  hkl_lamp_if.driver lamp
);

  logic [31:0] fast_cnt;
  logic [31:0] slow_cnt;
  logic        fast_ph;
  logic        slow_ph;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || fast_cnt == 32'(FAST_HALF - 1))
      fast_cnt <= 32'h00000000;
    else
      fast_cnt <= fast_cnt + 32'h00000001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || slow_cnt == 32'(SLOW_HALF - 1))
      slow_cnt <= 32'h00000000;
    else
      slow_cnt <= slow_cnt + 32'h00000001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fast_ph <= 1'b0;
      slow_ph <= 1'b0;
    end
    else
    begin
      if (fast_cnt == 32'(FAST_HALF - 1))
        fast_ph <= ~fast_ph;
      if (slow_cnt == 32'(SLOW_HALF - 1))
        slow_ph <= ~slow_ph;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lamp.lit <= 12'h000;
    else
      for (int i = 0; i < 12; i++)
      begin
        unique case (hkl_led_code_type'(lamp.code[2*i +: 2])) // R12
          HKL_LED_OFF:  lamp.lit[i] <= 1'b0;
          HKL_LED_FAST: lamp.lit[i] <= fast_ph;
          HKL_LED_SLOW: lamp.lit[i] <= slow_ph;
          HKL_LED_ON:   lamp.lit[i] <= 1'b1;
        endcase
      end
  end

endmodule // hkl_lamp_driver
`default_nettype wire

/* hkl_key_led_image.sv */
// Purpose: operator controls to input image, output image and tags to LEDs
// Assumes: pins are asynchronous; Wishbone master on clk_i
// Notes: the controller side of the fieldbus reads and writes the image registers
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "hkl_consts.svh"
module hkl_key_led_image
  import hkl_pkg::*;
#(
  parameter hkl_variant_type VARIANT   = HKL_VAR_LARGE,
  parameter int unsigned     FAST_HALF = `HKL_FAST_HALF_CYC,
  parameter int unsigned     SLOW_HALF = `HKL_SLOW_HALF_CYC
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // operator controls
  input  wire logic [9:0]  fkey_i,
  input  wire logic        left_lit_button_i,
  input  wire logic        right_lit_button_i,
  input  wire logic        keysw_cw_i,
  input  wire logic        keysw_ccw_i,
  input  wire logic [31:0] touch_i,
  // device state
  input  wire logic        fieldbus_link_i,
  input  wire logic        runtime_started_i,
  input  wire logic        box_attached_i,
  // lamps and results
  output logic      [11:0] led_o,
  output logic      [1:0]  mode_o,
  output logic      [9:0]  fn_local_o,
  output logic      [9:0]  fn_global_o,
  output logic             irq_o
);

  logic [48:0]  pin_meta;
  logic [48:0]  pin_sync;
  logic [9:0]   fkey_s;
  logic         left_s;
  logic         right_s;
  logic         cw_s;
  logic         ccw_s;
  logic [31:0]  touch_s;
  logic         link_s;
  logic         run_s;
  logic         box_s;
  logic         link_q;
  logic [9:0]   key_mask;
  logic         exchange_on;
  logic         key_lock_pos_hi;
  logic         key_lock_pos_lo;
  logic [47:0]  in_img;
  logic [47:0]  next_in_img;
  logic [15:0]  out_img;
  logic [23:0]  led_tag;
  hkl_mode_type mode;
  logic [9:0]   local_assign;
  logic [3:0]   irq_stat;
  logic [3:0]   irq_mask;
  logic [3:0]   irq_event;
  logic         wb_req;
  logic         wb_wr;
  logic         wb_rd;
  logic [31:0]  next_rdata;
  logic [23:0]  next_code;
  hkl_mode_type wr_mode;

  hkl_lamp_if lamp_bus ();

  // byte-lane merge for partial writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        res[8*b +: 8] = new_v[8*b +: 8];
    return res;
  endfunction

  // position of lamp or key i in the 16-bit image
  function automatic logic [3:0] img_pos(input int i);
    logic [3:0] p;
    p = 4'(i);
    if (i == 10)
      p = 4'(`HKL_POS_LEFT);
    if (i == 11)
      p = 4'(`HKL_POS_RIGHT);
    return p;
  endfunction

  // pins pass two flops before any use
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta <= 49'h0000000000000;
      pin_sync <= 49'h0000000000000;
    end
    else
    begin
      pin_meta <= {box_attached_i, runtime_started_i, fieldbus_link_i, touch_i, keysw_ccw_i, keysw_cw_i,
                   right_lit_button_i, left_lit_button_i, fkey_i};
      pin_sync <= pin_meta;
    end
  end

  assign fkey_s  = pin_sync[9:0];
  assign left_s  = pin_sync[10];
  assign right_s = pin_sync[11];
  assign cw_s    = pin_sync[12];
  assign ccw_s   = pin_sync[13];
  assign touch_s = pin_sync[45:14];
  assign link_s  = pin_sync[46];
  assign run_s   = pin_sync[47];
  assign box_s   = pin_sync[48];

  // keys present on this variant
  assign key_mask = (VARIANT == HKL_VAR_SMALL) ? 10'h00F :                   // R02
                    (VARIANT == HKL_VAR_MID)   ? 10'h0FF : 10'h3FF;          // R05

  // offline mode has no controller traffic, so no image either
  assign exchange_on = link_s && mode == HKL_MODE_ONLINE;                     // R09

  // clockwise wins if both contacts ever read closed
  assign key_lock_pos_lo = cw_s;                                              // R04
  assign key_lock_pos_hi = ccw_s && !cw_s;                                    // R04

  always_comb
  begin
    next_in_img = 48'h000000000000;                                           // R15
    if (exchange_on)
    begin
      if (run_s)                                                              // R10
      begin
        next_in_img[7:0]   = fkey_s[7:0] & key_mask[7:0];                     // R01 R02
        next_in_img[`HKL_POS_KEY_NINE] = fkey_s[8] & key_mask[8];             // R05
        next_in_img[`HKL_POS_KEY_TEN]  = fkey_s[9] & key_mask[9];             // R05
        next_in_img[47:16] = touch_s;                                         // R06
      end
      if (box_s)                                                              // R11
      begin
        next_in_img[`HKL_POS_RIGHT] = right_s;                                // R03 R07
        next_in_img[`HKL_POS_LEFT]  = left_s;                                 // R03 R07
        if (VARIANT != HKL_VAR_SMALL)
        begin
          next_in_img[`HKL_POS_LOCK_HI] = key_lock_pos_hi;                    // R04
          next_in_img[`HKL_POS_LOCK_LO] = key_lock_pos_lo;                    // R04
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      in_img <= 48'h000000000000;
    else
      in_img <= next_in_img;
  end

  // lamp codes: off without runtime (keys) or box (buttons); else, while linked and online, a set image bit is steady on, else the tag field decides
  always_comb
  begin
    next_code = 24'h000000;
    for (int i = 0; i < 12; i++)
    begin
      if ((i < 10) ? (run_s && key_mask[i]) : box_s)                          // R10 R11 R15
      begin
        if (exchange_on && out_img[img_pos(i)])                               // R08 R09
          next_code[2*i +: 2] = HKL_LED_ON;
        else
          next_code[2*i +: 2] = led_tag[2*i +: 2];                            // R12
      end
    end
  end

  assign lamp_bus.code = next_code;

  hkl_lamp_driver #(
    .FAST_HALF (FAST_HALF),
    .SLOW_HALF (SLOW_HALF)
  ) u_lamp (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .lamp  (lamp_bus)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      led_o <= 12'h000;
    else
      led_o <= lamp_bus.lit;
  end

  // one function per key: local claims it, global gets it otherwise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fn_local_o  <= 10'h000;
      fn_global_o <= 10'h000;
    end
    else
    begin
      fn_local_o  <= run_s ? (fkey_s & key_mask & local_assign) : 10'h000;    // R13
      fn_global_o <= run_s ? (fkey_s & key_mask & ~local_assign) : 10'h000;   // R13
    end
  end

  // wishbone: one wait state, ack for any address
  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr   = wb_req && wb_we_i;
  assign wb_rd   = wb_req && !wb_we_i;
  assign wr_mode = hkl_mode_type'(wb_dat_i[1:0]);

  always_comb
  begin
    unique case (wb_adr_i)
      `HKL_ADR_IN_LO:    next_rdata = in_img[31:0];
      `HKL_ADR_IN_HI:    next_rdata = {16'h0000, in_img[47:32]};
      `HKL_ADR_OUT_IMG:  next_rdata = {16'h0000, out_img};
      `HKL_ADR_LED_TAG:  next_rdata = {8'h00, led_tag};
      `HKL_ADR_MODE:     next_rdata = {30'h00000000, mode};
      `HKL_ADR_LOCAL:    next_rdata = {22'h000000, local_assign};
      `HKL_ADR_IRQ_STAT: next_rdata = {28'h0000000, irq_stat};
      `HKL_ADR_IRQ_MASK: next_rdata = {28'h0000000, irq_mask};
      `HKL_ADR_LINK:     next_rdata = {29'h00000000, box_s, run_s, link_s};
      default:           next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_rd)
        wb_dat_o <= next_rdata;
    end
  end

  // control registers written by software
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_img      <= `HKL_RST_OUT_IMG;
      led_tag      <= `HKL_RST_LED_TAG;
      local_assign <= `HKL_RST_LOCAL;
      irq_mask     <= `HKL_RST_IRQ_MASK;
    end
    else if (wb_wr)
    begin
      unique case (wb_adr_i)
        `HKL_ADR_OUT_IMG:  out_img      <= 16'(lane_merge({16'h0000, out_img}, wb_dat_i, wb_sel_i));
        `HKL_ADR_LED_TAG:  led_tag      <= 24'(lane_merge({8'h00, led_tag}, wb_dat_i, wb_sel_i));
        `HKL_ADR_LOCAL:    local_assign <= 10'(lane_merge({22'h000000, local_assign}, wb_dat_i, wb_sel_i));
        `HKL_ADR_IRQ_MASK: irq_mask     <= 4'(lane_merge({28'h0000000, irq_mask}, wb_dat_i, wb_sel_i));
        default:           out_img      <= out_img;
      endcase
    end
  end

  // undefined mode code is ignored; starts offline
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode <= HKL_MODE_OFFLINE;
    else if (wb_wr && wb_adr_i == `HKL_ADR_MODE && wb_sel_i[0] && wr_mode != 2'b11)
      mode <= wr_mode;                                                        // R14
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode_o <= HKL_MODE_OFFLINE;
    else
      mode_o <= mode;                                                         // R14
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      link_q <= 1'b0;
    else
      link_q <= link_s;
  end

  always_comb
  begin
    irq_event = 4'h0;
    irq_event[`HKL_IRQ_IN_CHANGE] = next_in_img != in_img;
    irq_event[`HKL_IRQ_OUT_WRITE] = wb_wr && wb_adr_i == `HKL_ADR_OUT_IMG;
    irq_event[`HKL_IRQ_MODE]      = wb_wr && wb_adr_i == `HKL_ADR_MODE && wb_sel_i[0] &&
                                    wr_mode != 2'b11 && wr_mode != mode;
    irq_event[`HKL_IRQ_LINK]      = link_s != link_q;
  end

  // read clears what was seen; a same-cycle event still sets
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat <= 4'h0;
    else if (wb_rd && wb_adr_i == `HKL_ADR_IRQ_STAT)
      irq_stat <= irq_event;
    else
      irq_stat <= irq_stat | irq_event;
  end

  // level, one cycle behind the status bits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_stat & irq_mask);
  end

endmodule // hkl_key_led_image
`default_nettype wire

/* hkl_key_led_image_sva.sv */
// Purpose: port-level checks of the key and LED image block
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every instance of the top module
`timescale 1ns/10ps
`default_nettype none
`include "hkl_consts.svh"
module hkl_key_led_image_sva
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // state and results
  input wire logic        runtime_started_i,
  input wire logic        box_attached_i,
  input wire logic [11:0] led_o,
  input wire logic [1:0]  mode_o,
  input wire logic [9:0]  fn_local_o,
  input wire logic [9:0]  fn_global_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic taken;
  logic mode_wr;
  assign taken   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign mode_wr = taken && wb_we_i && wb_adr_i == `HKL_ADR_MODE && wb_sel_i[0];

  ack_follows_a: assert property (taken |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > `HKL_ADR_LINK |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  mode_write_a: assert property (mode_wr && wb_dat_i[1:0] != 2'b11 |-> ##2 mode_o == $past(wb_dat_i[1:0], 2))
    else $error("mode output misses written mode");
  mode_keep_a: assert property (mode_wr && wb_dat_i[1:0] == 2'b11 |-> ##2 mode_o == $past(mode_o, 2))
    else $error("illegal mode code changed the mode");
  mode_legal_a: assert property (mode_o != 2'b11)
    else $error("mode output has unused code");
  mode_reset_a: assert property ($fell(rst_i) |-> mode_o == 2'b00)
    else $error("mode not offline after reset");
  fn_single_a: assert property ((fn_local_o & fn_global_o) == 10'h000)
    else $error("key has local and global function at once");
  fkey_led_off_a: assert property (!runtime_started_i [*8] |-> led_o[9:0] == 10'h000)
    else $error("key lamp lit without runtime");
  lit_led_off_a: assert property (!box_attached_i [*8] |-> led_o[11:10] == 2'b00)
    else $error("button lamp lit without box");

  cover property (mode_wr);
  cover property (wb_ack_o && !wb_we_i && wb_adr_i == `HKL_ADR_IN_LO && wb_dat_o != 32'h0);
  cover property (led_o[0] ##1 !led_o[0]);
endmodule // hkl_key_led_image_sva

bind hkl_key_led_image hkl_key_led_image_sva i_hkl_key_led_image_sva
(
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .runtime_started_i, .box_attached_i, .led_o, .mode_o, .fn_local_o, .fn_global_o
);
`default_nettype wire

/* hkl_ctrl_model.sv */
// Purpose: controller side that reads and writes the image registers
// Assumes: classic Wishbone single cycles on clk_i
// Notes: gives up after 50 cycles without ack and raises timed_out_o
`timescale 1ns/10ps
`default_nettype none
module hkl_ctrl_model
(
  // clock
  input  wire logic        clk_i,
  // wishbone master
  output var  logic        wb_cyc_o,
  output var  logic        wb_stb_o,
  output var  logic        wb_we_o,
  output var  logic [7:0]  wb_adr_o,
  output var  logic [3:0]  wb_sel_o,
  output var  logic [31:0] wb_dat_o,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i,
  // watchdog
  output var  logic        timed_out_o
);
  initial
  begin
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o, timed_out_o} = '0;
  end

  // call just after a rising edge; request held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
    int n;
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= w;
    wb_adr_o <= a;
    wb_sel_o <= s;
    wb_dat_o <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (!wb_ack_i && n < 50);
    q = wb_dat_i;
    timed_out_o <= !wb_ack_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // released data must not look valid
    wb_dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule // hkl_ctrl_model
`default_nettype wire

/* testbench.sv */
// Purpose: self-checking bench of the key and LED image block
// Assumes: short flash half periods so both blink rates show in 42 cycles
// Notes: pins need 3 edges into the image, so reads wait 5
`timescale 1ns/10ps
`default_nettype none
`include "hkl_consts.svh"
module testbench
  import hkl_pkg::*;
;
  localparam int FH = 3;
  localparam int SH = 7;
  logic        clk_i = 1'b0;
  logic        rst_i;
  logic        cyc, stb, we, ack, tmo, lb, rb, cw, ccw, link, run, box, irq, lv;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dw, dr, q, touch;
  logic [9:0]  fkey, loc, fnl, fng;
  logic [11:0] led;
  logic [1:0]  mode, md;
  logic [15:0] o;
  logic [47:0] e;
  int          n_fail = 0;
  int          checks = 0;
  int          i, k, on, tg;
  logic [7:0]  zadr [8] = '{`HKL_ADR_OUT_IMG, `HKL_ADR_LED_TAG, `HKL_ADR_MODE, `HKL_ADR_LOCAL,
                             `HKL_ADR_IRQ_MASK, `HKL_ADR_IN_LO, `HKL_ADR_IN_HI, 8'h40};
  logic [1:0]  mcode [6] = '{2'b11, HKL_MODE_LOAD, HKL_MODE_ONLINE, HKL_MODE_OFFLINE, 2'b11, HKL_MODE_ONLINE};

  always #10 clk_i = ~clk_i;

  hkl_ctrl_model i_hkl_ctrl_model
  (
    .clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
    .wb_dat_o(dw), .wb_dat_i(dr), .wb_ack_i(ack), .timed_out_o(tmo)
  );

  hkl_key_led_image #(.VARIANT(HKL_VAR_LARGE), .FAST_HALF(FH), .SLOW_HALF(SH)) i_hkl_key_led_image
  (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .fkey_i(fkey),
    .left_lit_button_i(lb), .right_lit_button_i(rb), .keysw_cw_i(cw), .keysw_ccw_i(ccw),
    .touch_i(touch), .fieldbus_link_i(link), .runtime_started_i(run), .box_attached_i(box),
    .led_o(led), .mode_o(mode), .fn_local_o(fnl), .fn_global_o(fng), .irq_o(irq)
  );

  task automatic end_of_test;
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    i_hkl_ctrl_model.xfer(w, a, d, s, q);
    if (tmo)
    begin
      n_fail++;
      end_of_test;
    end
  endtask

  // image only while linked and online; cw wins when both switch pins are high
  function automatic logic [47:0] img(input logic [1:0] m);
    logic [47:0] v;
    v = 48'h0;
    if (link && m == HKL_MODE_ONLINE && run)
      v = {touch, 6'h00, fkey};
    if (link && m == HKL_MODE_ONLINE && box)
      v[15:12] = {rb, lb, (cw ? 2'b01 : {ccw, 1'b0})};
    return v;
  endfunction

  // window on toggles allows for either phase and a half period of N or N+1
  function automatic logic tag_ok(input int c, input int n_on, input int n_tg);
    int h;
    h = (c == 1) ? FH : SH;
    if (c == 0)
      return n_on == 0;
    if (c == 3)
      return n_on == 42;
    return n_tg >= 42 / (h + 1) - 1 && n_tg <= 42 / h + 1;
  endfunction

  initial
  begin
    void'($urandom(65102));
    rst_i = 1'b1;
    md = HKL_MODE_OFFLINE;
    {fkey, lb, rb, cw, ccw, touch, link, run, box} = '1;
    tick(3);
    rst_i <= 1'b0;
    tick(2);
    chk(mode, 2'b00);
    foreach (zadr[i])
    begin
      bus(1'b0, zadr[i], 32'h0);
      chk(q, 48'h0);
    end
    bus(1'b0, `HKL_ADR_LINK, 32'h0);
    chk(q, 48'h7);
    foreach (mcode[k])
    begin
      bus(1'b1, `HKL_ADR_MODE, {30'h0, mcode[k]});
      md = (mcode[k] == 2'b11) ? md : mcode[k];
      tick(3);
      chk(mode, md);
      bus(1'b0, `HKL_ADR_IN_LO, 32'h0);
      e = img(md);
      chk(q, e[31:0]);
    end
    for (i = 0; i < 16; i++)
    begin
      fkey <= 10'($urandom);
      touch <= $urandom;
      {lb, rb, cw, ccw} <= (i == 0) ? 4'hF : 4'($urandom);
      {link, run, box} <= (i == 0) ? 3'h7 : 3'($urandom | $urandom);
      tick(5);
      e = img(md);
      bus(1'b0, `HKL_ADR_IN_LO, 32'h0);
      chk(q, e[31:0]);
      bus(1'b0, `HKL_ADR_IN_HI, 32'h0);
      chk(q, {16'h0, e[47:32]});
    end
    {link, run, box} <= 3'h7;
    tick(5);
    for (i = 0; i < 6; i++)
    begin
      o = 16'($urandom);
      loc = 10'($urandom);
      fkey <= 10'($urandom);
      bus(1'b1, `HKL_ADR_OUT_IMG, {16'h0, o});
      bus(1'b1, `HKL_ADR_LOCAL, {22'h0, loc});
      tick(5);
      chk(led, {o[15:14], o[9:0]});
      chk({fnl, fng}, {fkey & loc, fkey & ~loc});
    end
    bus(1'b1, `HKL_ADR_OUT_IMG, 32'h0);
    for (k = 0; k < 4; k++)
    begin
      bus(1'b1, `HKL_ADR_LED_TAG, {8'h0, {12{2'(k)}}});
      tick(4);
      on = 0;
      tg = 0;
      lv = led[0];
      for (i = 0; i < 42; i++)
      begin
        @(posedge clk_i);
        on += led[0];
        tg += (led[0] != lv);
        lv = led[0];
      end
      chk(tag_ok(k, on, tg), 1'b1);
    end
    // byte enables: only the low lane of the output image may change
    bus(1'b1, `HKL_ADR_OUT_IMG, 32'hFFFF, 4'h1);
    bus(1'b0, `HKL_ADR_OUT_IMG, 32'h0);
    chk(q, 48'hFF);
    bus(1'b1, `HKL_ADR_IRQ_MASK, 32'h1);
    bus(1'b0, `HKL_ADR_IRQ_STAT, 32'h0);
    tick(2);
    chk(irq, 1'b0);
    fkey <= ~fkey;
    tick(6);
    chk(irq, 1'b1);
    bus(1'b0, `HKL_ADR_IRQ_STAT, 32'h0);
    chk(q, 48'h1);
    tick(2);
    chk(irq, 1'b0);
    bus(1'b1, `HKL_ADR_IRQ_MASK, 32'h0);
    fkey <= ~fkey;
    tick(6);
    chk(irq, 1'b0);
    link <= 1'b0;
    tick(5);
    bus(1'b0, `HKL_ADR_IN_LO, 32'h0);
    chk(q, 48'h0);
    // key flip and link drop both left their marks
    bus(1'b0, `HKL_ADR_IRQ_STAT, 32'h0);
    chk(q, 48'h9);
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
